// >>> logic/lis_pkg.sv
// Shared constants and types for the display interrupt status block.
package lis_pkg;

	// Register bus geometry (byte addresses, 32-bit words).
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam logic [11:0] OFS_RAW_EVENT_STATUS = 12'h0020;
	localparam logic [11:0] OFS_MASKED_EVENT_STATUS = 12'h0024;

	// Event field layout, shared by raw and masked views.
	localparam int unsigned NUM_EVENTS = 4;
	localparam int unsigned EV_LSB = 1;
	localparam int unsigned EV_MSB = 4;
	localparam int unsigned BIT_FIFO_UNDERFLOW = 1;
	localparam int unsigned BIT_NEXT_BASE_UPDATE = 2;
	localparam int unsigned BIT_VERTICAL_COMPARE = 3;
	localparam int unsigned BIT_BUS_ERROR = 4;

	// Reset values.
	localparam logic [31:0] RAW_EVENT_STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASKED_EVENT_STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

	// Vertical region choice, control field bits 13:12.
	localparam logic [1:0] VREGION_SYNC = 2'h0;
	localparam logic [1:0] VREGION_BACK_PORCH = 2'h1;
	localparam logic [1:0] VREGION_ACTIVE = 2'h2;
	localparam logic [1:0] VREGION_FRONT_PORCH = 2'h3;

	// Bus master error tracker states.
	typedef enum logic [1:0] {
		LIS_MB_RUN = 2'b01,
		LIS_MB_ERROR = 2'b10
	} lis_mb_state_e;

endpackage

// >>> logic/lis_sticky_events.sv
// Sticky event flags with write-one-to-clear, set winning over clear.
`timescale 1ns/100ps
`default_nettype none

module lis_sticky_events (
	input wire logic clk_in, // System clock.
	input wire logic srst_in, // Synchronous reset, active high.
	input wire logic [lis_pkg::NUM_EVENTS-1:0] set_in, // Event pulses.
	input wire logic [lis_pkg::NUM_EVENTS-1:0] clr_in, // Clear strobes.
	output logic [lis_pkg::NUM_EVENTS-1:0] flag_out // Latched flags.
);

	genvar i;
	generate
		for (i = 0; i < lis_pkg::NUM_EVENTS; i = i + 1) begin : g_flag
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					flag_out[i] <= lis_pkg::RAW_EVENT_STATUS_RESET[lis_pkg::EV_LSB + i];
				end else if (set_in[i]) begin
					flag_out[i] <= 1'b1;
				end else if (clr_in[i]) begin
					flag_out[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// >>> logic/lis_bus_error_track.sv
// Tracks the display bus master's error state after an ERROR response.
`timescale 1ns/100ps
`default_nettype none

module lis_bus_error_track (
	input wire logic clk_in, // System clock.
	input wire logic srst_in, // Synchronous reset, active high.
	input wire logic error_resp_in, // Slave answered ERROR this cycle.
	input wire logic error_cleared_in, // Indication that the error is cleared.
	output logic error_event_out, // High in every cycle an ERROR response arrives, halted or not.
	output logic master_halt_out // High while normal operation is stopped.
);

	lis_pkg::lis_mb_state_e state;
	lis_pkg::lis_mb_state_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			lis_pkg::LIS_MB_RUN: begin
				if (error_resp_in) begin
					next_state = lis_pkg::LIS_MB_ERROR;
				end
			end
			lis_pkg::LIS_MB_ERROR: begin
				if (error_cleared_in) begin
					next_state = lis_pkg::LIS_MB_RUN;
				end
			end
			default: begin
				next_state = lis_pkg::LIS_MB_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state <= lis_pkg::LIS_MB_RUN;
		end else begin
			state <= next_state;
		end
	end

	assign error_event_out = error_resp_in;
	// A fresh ERROR while already halted still counts, so software sees repeats.
	assign master_halt_out = (state == lis_pkg::LIS_MB_ERROR);

endmodule

`default_nettype wire

// >>> logic/lis_top.sv
// Interrupt status logic of the display controller with a Wishbone slave.
//
// Operation
// - Raw status read returns four latched events.
// - Writing one clears matching event bit.
// - Bits 31:5 and 0 read zero.
// - Bus ERROR response sets bit four.
// - Master halts in error until cleared.
// - Selected vertical region start sets bit three.
// - Base loaded into incrementer sets bit two.
// - Read from empty FIFO sets bit one.
// - Upper and lower underflows ORed together.
// - Masked register is read-only raw AND enable.
// - One interrupt output ORs masked bits.
// - Masked bits four to one carry events.
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module lis_top (
	input wire logic clk_in, // 20 MHz system clock.
	input wire logic srst_in, // Synchronous reset, active high.
	// Wishbone classic slave.
	input wire logic wb_cyc_in, // Bus cycle.
	input wire logic wb_stb_in, // Strobe.
	input wire logic wb_we_in, // Write enable.
	input wire logic [lis_pkg::ADDR_W-1:0] wb_adr_in, // Byte address.
	input wire logic [3:0] wb_sel_in, // Byte lane selects.
	input wire logic [lis_pkg::DATA_W-1:0] wb_dat_in, // Write data.
	output logic [lis_pkg::DATA_W-1:0] wb_dat_out, // Read data.
	output logic wb_ack_out, // Acknowledge.
	// Enable register, bits 4:1 of its word.
	input wire logic [lis_pkg::NUM_EVENTS-1:0] event_enable_in, // Mask enables.
	// Vertical compare selection, control bits 13:12.
	input wire logic [1:0] vcompare_select_in, // Region choice.
	// Timing generator region starts, one-cycle pulses.
	input wire logic vsync_start_in, // Vertical sync begins.
	input wire logic back_porch_start_in, // Back porch begins.
	input wire logic active_start_in, // Active video begins.
	input wire logic front_porch_start_in, // Front porch begins.
	// Frame address incrementers.
	input wire logic upper_base_load_in, // Upper base taken into its incrementer.
	input wire logic lower_base_load_in, // Lower base taken into its incrementer.
	// DMA FIFOs.
	input wire logic upper_fifo_read_in, // Pixel read from upper FIFO.
	input wire logic upper_fifo_empty_in, // Upper FIFO empty.
	input wire logic lower_fifo_read_in, // Pixel read from lower FIFO.
	input wire logic lower_fifo_empty_in, // Lower FIFO empty.
	// Display bus master.
	input wire logic master_error_resp_in, // ERROR response received.
	input wire logic master_error_cleared_in, // Error cleared indication.
	output logic master_halt_out, // Master stopped in error state.
	// System interrupt controller.
	output logic irq_out // Combined interrupt, active high level.
);

	// Bus handshake.
	logic bus_req;
	logic bus_take;
	logic hit_raw;
	logic hit_masked;
	logic raw_write;

	// Event datapath.
	logic [lis_pkg::NUM_EVENTS-1:0] event_set;
	logic [lis_pkg::NUM_EVENTS-1:0] event_clr;
	logic [lis_pkg::NUM_EVENTS-1:0] event_flag;
	logic [lis_pkg::NUM_EVENTS-1:0] masked_flag;
	logic bus_error_event;
	logic vertical_compare_event;
	logic next_base_update_event;
	logic fifo_underflow_event;
	logic upper_underflow;
	logic lower_underflow;

	// Register views.
	logic [lis_pkg::DATA_W-1:0] raw_view;
	logic [lis_pkg::DATA_W-1:0] masked_view;
	logic [lis_pkg::DATA_W-1:0] next_rdata;

	// ------------------------------------------------------------------
	// Wishbone slave: ack one cycle after the request, one cycle wide.
	// ------------------------------------------------------------------

	assign bus_req = wb_cyc_in & wb_stb_in;
	assign bus_take = bus_req & ~wb_ack_out;
	assign hit_raw = (wb_adr_in[lis_pkg::ADDR_W-1:2] == lis_pkg::OFS_RAW_EVENT_STATUS[11:2]);
	assign hit_masked = (wb_adr_in[lis_pkg::ADDR_W-1:2]
		== lis_pkg::OFS_MASKED_EVENT_STATUS[11:2]);

	// The write acts at the edge where the master samples ack, so a request
	// that is withdrawn early never half-clears the flags.
	assign raw_write = bus_req & wb_ack_out & wb_we_in & hit_raw & wb_sel_in[0];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= bus_take;
		end
	end

	always_comb begin
		next_rdata = lis_pkg::UNMAPPED_READ_VALUE;
		if (hit_raw) begin
			next_rdata = raw_view;
		end else if (hit_masked) begin
			next_rdata = masked_view;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wb_dat_out <= lis_pkg::RAW_EVENT_STATUS_RESET;
		end else if (bus_take & ~wb_we_in) begin
			wb_dat_out <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Event sources.
	// ------------------------------------------------------------------

	lis_bus_error_track u_bus_error (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.error_resp_in(master_error_resp_in),
		.error_cleared_in(master_error_cleared_in),
		.error_event_out(bus_error_event),
		.master_halt_out(master_halt_out)
	);

	always_comb begin
		case (vcompare_select_in)
			lis_pkg::VREGION_SYNC: begin
				vertical_compare_event = vsync_start_in;
			end
			lis_pkg::VREGION_BACK_PORCH: begin
				vertical_compare_event = back_porch_start_in;
			end
			lis_pkg::VREGION_ACTIVE: begin
				vertical_compare_event = active_start_in;
			end
			lis_pkg::VREGION_FRONT_PORCH: begin
				vertical_compare_event = front_porch_start_in;
			end
			default: begin
				vertical_compare_event = 1'b0;
			end
		endcase
	end

	assign next_base_update_event = upper_base_load_in | lower_base_load_in;

	assign upper_underflow = upper_fifo_read_in & upper_fifo_empty_in;
	assign lower_underflow = lower_fifo_read_in & lower_fifo_empty_in;
	assign fifo_underflow_event = upper_underflow | lower_underflow;

	// Flag vector index i holds register bit i+1.
	always_comb begin
		event_set = '0;
		event_set[lis_pkg::BIT_FIFO_UNDERFLOW - lis_pkg::EV_LSB] = fifo_underflow_event;
		event_set[lis_pkg::BIT_NEXT_BASE_UPDATE - lis_pkg::EV_LSB] = next_base_update_event;
		event_set[lis_pkg::BIT_VERTICAL_COMPARE - lis_pkg::EV_LSB] = vertical_compare_event;
		event_set[lis_pkg::BIT_BUS_ERROR - lis_pkg::EV_LSB] = bus_error_event;
	end

	// clear only where data bit is one
	assign event_clr = raw_write ? wb_dat_in[lis_pkg::EV_MSB:lis_pkg::EV_LSB] : '0;

	lis_sticky_events u_events (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.set_in(event_set),
		.clr_in(event_clr),
		.flag_out(event_flag)
	);

	// ------------------------------------------------------------------
	// Views and interrupt.
	// ------------------------------------------------------------------

	assign masked_flag = event_flag & event_enable_in;

	always_comb begin
		raw_view = lis_pkg::RAW_EVENT_STATUS_RESET;
		masked_view = lis_pkg::MASKED_EVENT_STATUS_RESET;
		raw_view[lis_pkg::EV_MSB:lis_pkg::EV_LSB] = event_flag;
		// masked bits at four to one
		masked_view[lis_pkg::EV_MSB:lis_pkg::EV_LSB] = masked_flag;
	end

	// Registered so the line to the interrupt controller is glitch free; it
	// trails the flags by one cycle.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |masked_flag;
		end
	end

endmodule

`default_nettype wire

// >>> verification/lis_top_monitor.sv
// Port checks for the display interrupt status block.
`timescale 1ns/100ps
`default_nettype none
module lis_top_monitor (
	input wire logic clk_in, // Clock.
	input wire logic srst_in, // Reset.
	input wire logic wb_cyc_in, // Cycle.
	input wire logic wb_stb_in, // Strobe.
	input wire logic wb_we_in, // Write.
	input wire logic [lis_pkg::DATA_W-1:0] wb_dat_out, // Read data.
	input wire logic wb_ack_out, // Ack.
	input wire logic [lis_pkg::NUM_EVENTS-1:0] event_enable_in, // Enables.
	input wire logic upper_fifo_read_in, // Upper read.
	input wire logic upper_fifo_empty_in, // Upper empty.
	input wire logic master_error_resp_in, // Error seen.
	input wire logic master_error_cleared_in, // Error cleared.
	input wire logic master_halt_out, // Halted.
	input wire logic irq_out // Interrupt.
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
	sequence s_uf;
		upper_fifo_read_in && upper_fifo_empty_in && event_enable_in[0] ##1 event_enable_in[0];
	endsequence
	property p_ack; s_req |=> wb_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack long");
	property p_rsv;
		wb_ack_out && !wb_we_in |-> wb_dat_out[31:5] == 27'h000_0000 && !wb_dat_out[0];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_halt_set; master_error_resp_in |=> master_halt_out; endproperty
	a_halt_set: assert property (p_halt_set) else $error("no halt");
	property p_halt_hold; master_halt_out && !master_error_cleared_in |=> master_halt_out; endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
	property p_halt_rel; master_error_cleared_in && !master_error_resp_in |=> !master_halt_out; endproperty
	a_halt_rel: assert property (p_halt_rel) else $error("halt stuck");
	property p_irq_off; event_enable_in == 4'h0 |=> !irq_out; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
	property p_irq_uf; s_uf |=> irq_out; endproperty
	a_irq_uf: assert property (p_irq_uf) else $error("underflow irq");
endmodule
bind lis_top lis_top_monitor mon (.*);
`default_nettype wire

// >>> verification/lis_intc_model.sv
// Interrupt controller model counting rises of the combined interrupt.
`timescale 1ns/100ps
`default_nettype none
module lis_intc_model (
	input wire logic clk_in, // Clock.
	input wire logic irq_in, // Combined interrupt.
	output var int raised_out // Rises seen.
);
	logic last = 1'b0;
	int cnt = 0;
	assign raised_out = cnt;
	always @(posedge clk_in) begin
		if (irq_in === 1'b1 && last !== 1'b1)
			cnt <= cnt + 1;
		last <= irq_in;
	end
endmodule
`default_nettype wire

// >>> verification/test_lis_top.sv
// Self-checking bench for the display interrupt status block.
`timescale 1ns/100ps
`default_nettype none
module test_lis_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [3:0] en = 4'h0;
	logic [1:0] vsel = 2'h0;
	logic [11:0] evs = 12'h000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dat_o;
	logic [31:0] rdat;
	logic ack;
	logic halt;
	logic irq;
	int raised;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	lis_top dut (.clk_in(clk), .srst_in(srst), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(dat_o), .wb_ack_out(ack), .event_enable_in(en),
		.vcompare_select_in(vsel), .vsync_start_in(evs[0]), .back_porch_start_in(evs[1]),
		.active_start_in(evs[2]), .front_porch_start_in(evs[3]),
		.upper_base_load_in(evs[4]), .lower_base_load_in(evs[5]),
		.upper_fifo_read_in(evs[6]), .upper_fifo_empty_in(evs[7]),
		.lower_fifo_read_in(evs[8]), .lower_fifo_empty_in(evs[9]),
		.master_error_resp_in(evs[10]), .master_error_cleared_in(evs[11]),
		.master_halt_out(halt), .irq_out(irq));
	lis_intc_model intc (.clk_in(clk), .irq_in(irq), .raised_out(raised));
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// The hit pattern rides along so an event can land on the ack edge.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [11:0] hit);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge clk);
		evs <= hit;
		while (ack !== 1'b1)
			@(posedge clk);
		rdat = dat_o;
		evs <= 12'h000;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000, 4'hF, 12'h000);
		chk(what, exp, rdat);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		bus(1'b1, a, d, s, 12'h000);
	endtask
	task automatic pulse(input logic [11:0] m);
		evs <= m;
		@(posedge clk);
		evs <= 12'h000;
		@(posedge clk);
	endtask
	task automatic t_events;
		logic [11:0] m [6] = '{12'h010, 12'h020, 12'h0C0, 12'h300, 12'h040, 12'h180};
		logic [31:0] e [6] = '{32'h0000_0004, 32'h0000_0004, 32'h0000_0002,
			32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
		for (int k = 0; k < 4; k++) begin
			vsel <= k[1:0];
			pulse(12'h001 << ((k + 1) % 4));
			rd(12'h020, 32'h0000_0000, "other region");
			pulse(12'h001 << k);
			rd(12'h020, 32'h0000_0008, "region");
			wr(12'h020, 32'h0000_0008, 4'hF);
		end
		for (int j = 0; j < 6; j++) begin
			pulse(m[j]);
			rd(12'h020, e[j], "event");
			wr(12'h020, 32'h0000_001E, 4'hF);
		end
	endtask
	task automatic t_mask;
		vsel <= 2'h0;
		en <= 4'h5;
		pulse(12'h4D1);
		rd(12'h020, 32'h0000_001E, "all events");
		wr(12'h020, 32'h0000_001E, 4'hE);
		rd(12'h020, 32'h0000_001E, "lane ignored");
		wr(12'h024, 32'h0000_001E, 4'hF);
		rd(12'h020, 32'h0000_001E, "masked write");
		rd(12'h024, 32'h0000_000A, "masked view");
		chk("irq", 32'h0000_0001, 32'(irq));
		rd(12'h100, 32'h0000_0000, "unmapped");
		wr(12'h020, 32'h0000_0004, 4'hF);
		rd(12'h020, 32'h0000_001A, "one cleared");
		// The clear also names bit two, so the event on the ack edge must win.
		bus(1'b1, 12'h020, 32'h0000_001E, 4'hF, 12'h010);
		rd(12'h020, 32'h0000_0004, "set wins");
		chk("irq off", 32'h0000_0000, 32'(irq));
		en <= 4'h2;
		rd(12'h024, 32'h0000_0004, "base masked");
		chk("raised", 32'h0000_0002, 32'(raised));
		wr(12'h020, 32'h0000_0004, 4'hF);
	endtask
	task automatic t_halt;
		chk("halt held", 32'h0000_0001, 32'(halt));
		pulse(12'h400);
		rd(12'h020, 32'h0000_0010, "error again");
		pulse(12'h800);
		chk("halt freed", 32'h0000_0000, 32'(halt));
		pulse(12'h400);
		chk("halt set", 32'h0000_0001, 32'(halt));
		pulse(12'h800);
		wr(12'h020, 32'h0000_0010, 4'hF);
	endtask
	// Software side: the update flag is read once set, then cleared by writing one to bit two.
	task automatic t_base;
		pulse(12'h020);
		rd(12'h020, 32'h0000_0004, "base taken");
		wr(12'h020, 32'h0000_0004, 4'hF);
		rd(12'h020, 32'h0000_0000, "base acknowledged");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(12'h020, 32'h0000_0000, "raw reset");
		rd(12'h024, 32'h0000_0000, "masked reset");
		t_events;
		t_mask;
		t_halt;
		t_base;
		pulse(12'h020);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		rd(12'h020, 32'h0000_0000, "mid reset");
		conclude;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			conclude;
		end
	end
endmodule
`default_nettype wire
